// [src/pmilc_ctrl.v]
// Purpose: serial management slave, interrupt register, crossover and loopback control
// Assumes: mgmt clock well below mclk/4, sampled with two flops
// Notes: data changes after the mgmt clock rising edge, sampled by host on the next rising edge
`include "pmilc_map.vh"

module pmilc_ctrl #(
  parameter REDUCED_PIN = 0,
  parameter [15:0] SENSE_CYCLES = `PMILC_SENSE_CYCLES
) (
  input wire mclk,
  input wire rst_n,
  input wire mgmt_clk,
  input wire mgmt_data_in,
  output reg mgmt_data_out_ff,
  output reg mgmt_data_oe_ff,
  input wire [2:0] unique_addr_strap,
  input wire broadcast_disable_strap,
  input wire [7:0] irq_events,
  output reg irq_out_ff,
  input wire link_up_100fd,
  input wire partner_on_pair_a,
  input wire partner_on_pair_b,
  output reg tx_on_pair_b_ff,
  output reg local_loop_ff,
  output reg loop_to_line_ff,
  output reg remote_loop_ff
);
  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_HDR = 3'd2;
  localparam ST_TA = 3'd3;
  localparam ST_DATA = 3'd4;

  reg [1:0] mc_sync_ff;
  reg [1:0] md_sync_ff;
  reg mc_prev_ff;
  reg strap_done_ff;
  reg [2:0] addr_ff;
  reg bcast_strap_ff;
  reg [3:0] strap_s1_ff;
  reg [3:0] strap_s2_ff;
  reg [2:0] state_ff;
  reg [5:0] cnt_ff;
  reg [11:0] hdr_ff;
  reg is_read_ff;
  reg hit_ff;
  reg [15:0] shift_ff;
  reg [15:0] basic_ff;
  reg [15:0] extra_ff;
  reg [7:0] int_en_ff;
  reg [7:0] int_st_ff;
  reg [15:0] ctrl2_ff;
  reg [1:0] sense_ff [0:1];
  reg [15:0] sense_cnt_ff;
  reg auto_sel_ff;

  wire mc_rise = mc_sync_ff[1] & ~mc_prev_ff;
  wire md = md_sync_ff[1];
  wire bcast_on = ~bcast_strap_ff & ~extra_ff[`PMILC_EX_BCAST_OFF];
  wire [4:0] phy_adr = hdr_ff[9:5];
  wire [4:0] reg_adr = hdr_ff[4:0];
  wire addr_hit = (phy_adr == {2'b00, addr_ff}) | (bcast_on & (phy_adr == 5'h00));
  wire rd_op = (hdr_ff[11:10] == 2'b10);
  // header decides here; frame flags still belong to the last frame
  wire read_int = mc_rise & (state_ff == ST_TA) & (cnt_ff == 6'd0) & addr_hit & rd_op
    & (reg_adr == `PMILC_REG_INTR);
  wire wr_done = mc_rise & (state_ff == ST_DATA) & (cnt_ff == 6'd15) & hit_ff & ~is_read_ff;
  wire [15:0] wr_word = {shift_ff[14:0], md};
  wire irq_act = |(int_en_ff & int_st_ff);

  // register read mux; unmapped numbers read zero
  function [15:0] rd_mux;
    input [4:0] a;
    begin
      if (a == `PMILC_REG_BASIC) begin
        rd_mux = basic_ff;
      end else if (a == `PMILC_REG_EXTRA) begin
        rd_mux = extra_ff;
      end else if (a == `PMILC_REG_INTR) begin
        rd_mux = {int_en_ff, int_st_ff};
      end else if (a == `PMILC_REG_CTRL2) begin
        rd_mux = ctrl2_ff;
      end else begin
        rd_mux = 16'h0000;
      end
    end
  endfunction

  // local loopback decode: loop on, autoneg off, full duplex
  function loop_req;
    input [15:0] b;
    begin
      loop_req = b[`PMILC_BC_LOOP] & ~b[`PMILC_BC_ANEG] & b[`PMILC_BC_DUPLEX];
    end
  endfunction

  always @(posedge mclk) begin
    if (!rst_n) begin
      mc_sync_ff <= 2'b00;
      md_sync_ff <= 2'b11;
      mc_prev_ff <= 1'b0;
    end else begin
      mc_sync_ff <= {mc_sync_ff[0], mgmt_clk};
      md_sync_ff <= {md_sync_ff[0], mgmt_data_in};
      mc_prev_ff <= mc_sync_ff[1];
    end
  end

  // strap pins pass two flops before capture
  always @(posedge mclk) begin
    strap_s1_ff <= {broadcast_disable_strap, unique_addr_strap};
    strap_s2_ff <= strap_s1_ff;
  end

  // straps captured on the first clock after reset release
  always @(posedge mclk) begin
    if (!rst_n) begin
      strap_done_ff <= 1'b0;
      addr_ff <= 3'b000;
      bcast_strap_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      addr_ff <= strap_s2_ff[2:0];
      bcast_strap_ff <= strap_s2_ff[3];
    end
  end

  // frame engine
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 6'd0;
      hdr_ff <= 12'h000;
      is_read_ff <= 1'b0;
      hit_ff <= 1'b0;
      shift_ff <= 16'h0000;
      mgmt_data_out_ff <= 1'b0;
      mgmt_data_oe_ff <= 1'b0;
    end else if (mc_rise) begin
      case (state_ff)
        ST_IDLE: begin
          mgmt_data_oe_ff <= 1'b0;
          if (md) begin
            if (cnt_ff != `PMILC_PREAMBLE_LEN) begin
              cnt_ff <= cnt_ff + 6'd1;
            end
          end else if (cnt_ff == `PMILC_PREAMBLE_LEN) begin
            state_ff <= ST_START;
            cnt_ff <= 6'd0;
          end else begin
            cnt_ff <= 6'd0;
          end
        end
        ST_START: begin
          if (md) begin
            state_ff <= ST_HDR;
            cnt_ff <= 6'd0;
          end else begin
            state_ff <= ST_IDLE;
            cnt_ff <= 6'd0;
          end
        end
        ST_HDR: begin
          hdr_ff <= {hdr_ff[10:0], md};
          if (cnt_ff == 6'd11) begin
            state_ff <= ST_TA;
            cnt_ff <= 6'd0;
          end else begin
            cnt_ff <= cnt_ff + 6'd1;
          end
        end
        ST_TA: begin
          if (cnt_ff == 6'd0) begin
            // opcode 10 read, 01 write, else drop frame
            is_read_ff <= rd_op;
            hit_ff <= addr_hit & (hdr_ff[11] ^ hdr_ff[10]);
            if (rd_op && addr_hit) begin
              mgmt_data_out_ff <= 1'b0;
              mgmt_data_oe_ff <= 1'b1;
              shift_ff <= rd_mux(reg_adr);
            end
            cnt_ff <= 6'd1;
          end else begin
            state_ff <= ST_DATA;
            cnt_ff <= 6'd0;
            if (is_read_ff && hit_ff) begin
              mgmt_data_out_ff <= shift_ff[15];
              shift_ff <= {shift_ff[14:0], 1'b0};
            end
          end
        end
        default: begin
          if (!is_read_ff) begin
            shift_ff <= wr_word;
          end else if (hit_ff && cnt_ff != 6'd15) begin
            mgmt_data_out_ff <= shift_ff[15];
            shift_ff <= {shift_ff[14:0], 1'b0};
          end
          if (cnt_ff == 6'd15) begin
            mgmt_data_oe_ff <= 1'b0;
            state_ff <= ST_IDLE;
            cnt_ff <= 6'd0;
          end else begin
            cnt_ff <= cnt_ff + 6'd1;
          end
        end
      endcase
    end
  end

  // registers and interrupt status; a new event wins over read clear
  always @(posedge mclk) begin
    if (!rst_n) begin
      basic_ff <= `PMILC_BASIC_RST;
      extra_ff <= `PMILC_EXTRA_RST;
      ctrl2_ff <= `PMILC_CTRL2_RST;
      int_en_ff <= `PMILC_INTEN_RST;
      int_st_ff <= `PMILC_INTST_RST;
    end else begin
      if (wr_done) begin
        if (reg_adr == `PMILC_REG_BASIC) begin
          basic_ff <= wr_word;
        end else if (reg_adr == `PMILC_REG_EXTRA) begin
          extra_ff <= wr_word;
        end else if (reg_adr == `PMILC_REG_INTR) begin
          int_en_ff <= wr_word[15:8];
        end else if (reg_adr == `PMILC_REG_CTRL2) begin
          ctrl2_ff <= wr_word;
        end
      end
      int_st_ff <= (read_int ? 8'h00 : int_st_ff) | irq_events;
    end
  end

  // crossover sensing: alternate pairs until the partner is seen
  always @(posedge mclk) begin
    if (!rst_n) begin
      sense_ff[0] <= 2'b00;
      sense_ff[1] <= 2'b00;
      sense_cnt_ff <= 16'h0000;
      auto_sel_ff <= 1'b0;
    end else begin
      sense_ff[0] <= {sense_ff[0][0], partner_on_pair_a};
      sense_ff[1] <= {sense_ff[1][0], partner_on_pair_b};
      if (sense_ff[1][1] && !sense_ff[0][1]) begin
        auto_sel_ff <= 1'b0;
        sense_cnt_ff <= 16'h0000;
      end else if (sense_ff[0][1] && !sense_ff[1][1]) begin
        auto_sel_ff <= 1'b1;
        sense_cnt_ff <= 16'h0000;
      end else if (sense_cnt_ff == SENSE_CYCLES) begin
        auto_sel_ff <= ~auto_sel_ff;
        sense_cnt_ff <= 16'h0000;
      end else begin
        sense_cnt_ff <= sense_cnt_ff + 16'h0001;
      end
    end
  end

  // outputs
  always @(posedge mclk) begin
    if (!rst_n) begin
      irq_out_ff <= 1'b1;
      tx_on_pair_b_ff <= 1'b0;
      local_loop_ff <= 1'b0;
      loop_to_line_ff <= 1'b0;
      remote_loop_ff <= 1'b0;
    end else begin
      irq_out_ff <= (irq_act & ~read_int) ~^ ctrl2_ff[`PMILC_C2_IRQ_HIGH];
      if (ctrl2_ff[`PMILC_C2_AUTOX_OFF]) begin
        tx_on_pair_b_ff <= ctrl2_ff[`PMILC_C2_MDIX_SEL];
      end else begin
        tx_on_pair_b_ff <= auto_sel_ff;
      end
      local_loop_ff <= loop_req(basic_ff);
      loop_to_line_ff <= (REDUCED_PIN == 0) & loop_req(basic_ff);
      remote_loop_ff <= ctrl2_ff[`PMILC_C2_RLOOP] & (link_up_100fd | (basic_ff[`PMILC_BC_SPEED]
        & ~basic_ff[`PMILC_BC_ANEG] & basic_ff[`PMILC_BC_DUPLEX]));
    end
  end
endmodule // pmilc_ctrl

// [include/pmilc_map.vh]
// Purpose: constants for the management, interrupt and loopback control block
// Assumes: 16-bit registers, 5-bit register numbers
// Notes: reset values chosen to give documented defaults
`ifndef PMILC_MAP_VH
`define PMILC_MAP_VH
`define PMILC_REG_BASIC 5'h00
`define PMILC_REG_EXTRA 5'h16
`define PMILC_REG_INTR 5'h1b
`define PMILC_REG_CTRL2 5'h1f
`define PMILC_BC_LOOP 14
`define PMILC_BC_SPEED 13
`define PMILC_BC_ANEG 12
`define PMILC_BC_DUPLEX 8
`define PMILC_EX_BCAST_OFF 9
`define PMILC_C2_MDIX_SEL 14
`define PMILC_C2_AUTOX_OFF 13
`define PMILC_C2_IRQ_HIGH 9
`define PMILC_C2_RLOOP 2
`define PMILC_BASIC_RST 16'h3100
`define PMILC_EXTRA_RST 16'h0000
`define PMILC_CTRL2_RST 16'h0000
`define PMILC_INTEN_RST 8'h00
`define PMILC_INTST_RST 8'h00
`define PMILC_PREAMBLE_LEN 6'd32
`define PMILC_SENSE_CYCLES 16'h0fa0
`endif

// [tb/pmilc_ctrl_monitor.sv]
// Purpose: port checker for pmilc_ctrl
// Assumes: 8 mclk per management bit
// Notes: bound below
module pmilc_mon #(parameter REDUCED_PIN = 0) (
  input wire mclk,
  input wire rst_n,
  input wire mgmt_data_out_ff,
  input wire mgmt_data_oe_ff,
  input wire irq_out_ff,
  input wire local_loop_ff,
  input wire loop_to_line_ff,
  input wire remote_loop_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] oe_cnt_ff;
  default clocking @(posedge mclk); endclocking
  // cycles of the current answer
  always @(posedge mclk) begin
    if (!rst_n || !mgmt_data_oe_ff) oe_cnt_ff <= 8'h00;
    else oe_cnt_ff <= oe_cnt_ff + 8'h01;
  end
  AST_RST_OE: assert property (!rst_n |=> !mgmt_data_oe_ff)
    else $error("line driven after reset");
  AST_RST_IRQ: assert property (!rst_n |=> irq_out_ff)
    else $error("irq active after reset");
  AST_RST_LOOP: assert property (!rst_n |=> !local_loop_ff && !loop_to_line_ff && !remote_loop_ff)
    else $error("loop on after reset");
  AST_TA_ZERO: assert property (disable iff (!rst_n) $rose(mgmt_data_oe_ff) |-> !mgmt_data_out_ff)
    else $error("turnaround not zero");
  AST_BIT_HOLD: assert property (disable iff (!rst_n)
    mgmt_data_oe_ff && $changed(mgmt_data_out_ff) |=> $stable(mgmt_data_out_ff)[*6]) else $error("bit too short");
  AST_OE_LEN: assert property (disable iff (!rst_n)
    $fell(mgmt_data_oe_ff) |-> oe_cnt_ff >= 8'h80 && oe_cnt_ff <= 8'h90) else $error("answer length");
  AST_OE_GAP: assert property (disable iff (!rst_n) $fell(mgmt_data_oe_ff) |=> !mgmt_data_oe_ff[*8])
    else $error("line taken again");
  AST_LOOP_LINE: assert property (disable iff (!rst_n)
    $rose(local_loop_ff) |-> ##[0:2] (loop_to_line_ff == (REDUCED_PIN == 0))) else $error("line copy");
endmodule // pmilc_mon
bind pmilc_ctrl pmilc_mon #(.REDUCED_PIN(REDUCED_PIN)) pmilc_mon_inst (.mclk(mclk), .rst_n(rst_n),
  .mgmt_data_out_ff(mgmt_data_out_ff), .mgmt_data_oe_ff(mgmt_data_oe_ff), .irq_out_ff(irq_out_ff),
  .local_loop_ff(local_loop_ff), .loop_to_line_ff(loop_to_line_ff), .remote_loop_ff(remote_loop_ff));

// [tb/pmilc_host.sv]
// Purpose: management controller model
// Assumes: 8 mclk per bit, line pulled up
// Notes: clock stands low between frames
module pmilc_host (
  input wire mclk,
  input wire dev_oe,
  input wire dev_d,
  output logic mdc,
  output wire line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hd = 1'b1;
  logic hoe = 1'b0;
  initial mdc = 1'b0;
  assign line = dev_oe ? dev_d : (hoe ? hd : 1'b1);
  // 200 ns bit period
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'b01, op, pa, ra, ((op == 2'b01) ? 2'b10 : 2'b11), wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge mclk);
      mdc <= 1'b0;
      hd <= f[i];
      hoe <= (op != 2'b10) || (i > 17);
      repeat (4) @(posedge mclk);
      rd = {rd[14:0], line};
      mdc <= 1'b1;
      repeat (3) @(posedge mclk);
    end
    @(posedge mclk);
    mdc <= 1'b0;
    hoe <= 1'b0;
  endtask
endmodule // pmilc_host

// [tb/pmilc_ctrl_tb.sv]
// Purpose: self-checking bench for pmilc_ctrl
// Assumes: own address 5, strapped to 2 for the strap tests
// Notes: short crossover hunt
module pmilc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = 3'h5;
  logic bdis = 1'b0;
  logic [7:0] ev = 8'h00;
  logic lk = 1'b0;
  logic pa_e = 1'b0;
  logic pb_e = 1'b0;
  wire mdc, line, d_out, d_oe, irq, xb, ll, lt, rl;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'hba5a;
  logic [15:0] seen, r, d;
  logic seen_v = 1'b0;
  logic [15:0] exp_q[$];
  string nm_q[$];
  // basic, ctrl2, {lk,pa,pb}, {xb,ll,lt,rl}
  logic [39:0] row [6] = '{40'h41_0020_0006, 40'h61_0060_000e, 40'h51_0020_0400,
                           40'h21_0020_0401, 40'h31_0000_0469, 40'h31_0000_0050};
  always #12.5 mclk = ~mclk;
  pmilc_ctrl #(.SENSE_CYCLES(16'h0010)) pmilc_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .mgmt_clk(mdc),
    .mgmt_data_in(line), .mgmt_data_out_ff(d_out), .mgmt_data_oe_ff(d_oe), .unique_addr_strap(strap),
    .broadcast_disable_strap(bdis), .irq_events(ev), .irq_out_ff(irq), .link_up_100fd(lk),
    .partner_on_pair_a(pa_e), .partner_on_pair_b(pb_e), .tx_on_pair_b_ff(xb), .local_loop_ff(ll),
    .loop_to_line_ff(lt), .remote_loop_ff(rl));
  pmilc_host pmilc_host_inst (.mclk(mclk), .dev_oe(d_oe), .dev_d(d_out), .mdc(mdc), .line(line));
  always @(posedge mclk) begin
    if (seen_v) begin
      n_tests++;
      if (seen !== exp_q[0]) begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", nm_q[0], exp_q[0], seen);
      end
      exp_q.delete(0);
      nm_q.delete(0);
    end
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    exp_q.push_back(e);
    nm_q.push_back(n);
    seen <= g;
    seen_v <= 1'b1;
    @(posedge mclk);
    seen_v <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [4:0] a, logic [4:0] ra, logic [15:0] e);
    pmilc_host_inst.xfer(2'b10, a, ra, 16'h0000, r);
    chk($sformatf("reg %h", ra), e, r);
  endtask
  task automatic wr(logic [4:0] a, logic [4:0] ra, logic [15:0] v);
    pmilc_host_inst.xfer(2'b01, a, ra, v, r);
    repeat (6) @(posedge mclk);
  endtask
  task automatic pulse(logic [7:0] m);
    ev <= m;
    @(posedge mclk);
    ev <= 8'h00;
    repeat (2) @(posedge mclk);
  endtask
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(5'h05, 5'h00, 16'h3100);
    rd(5'h05, 5'h16, 16'h0000);
    rd(5'h05, 5'h1f, 16'h0000);
    rd(5'h05, 5'h10, 16'h0000);
    d = rnd() & 16'hfdff;
    wr(5'h05, 5'h16, d);
    rd(5'h05, 5'h16, d);
    wr(5'h03, 5'h16, 16'h0000);
    rd(5'h05, 5'h16, d);
    rd(5'h03, 5'h16, 16'hffff);
    wr(5'h00, 5'h16, 16'h0011);
    rd(5'h00, 5'h16, 16'h0011);
    wr(5'h05, 5'h16, 16'h0200);
    rd(5'h00, 5'h16, 16'hffff);
    wr(5'h05, 5'h16, 16'h0000);
    $display("end of frame tests");
    wr(5'h05, 5'h1b, 16'h0100);
    pulse(8'h02);
    chk("irq", 16'h0001, {15'h0000, irq});
    pulse(8'h01);
    chk("irq", 16'h0000, {15'h0000, irq});
    rd(5'h05, 5'h1b, 16'h0103);
    chk("irq", 16'h0001, {15'h0000, irq});
    rd(5'h05, 5'h1b, 16'h0100);
    wr(5'h05, 5'h1f, 16'h0200);
    pulse(8'h01);
    chk("irq", 16'h0001, {15'h0000, irq});
    rd(5'h05, 5'h1b, 16'h0101);
    chk("irq", 16'h0000, {15'h0000, irq});
    $display("end of interrupt tests");
    foreach (row[i]) begin
      {lk, pa_e, pb_e} <= row[i][6:4];
      wr(5'h05, 5'h00, row[i][39:24]);
      wr(5'h05, 5'h1f, row[i][23:8]);
      chk("modes", {12'h000, row[i][3:0]}, {12'h000, xb, ll, lt, rl});
    end
    $display("end of mode tests");
    rst_n <= 1'b0;
    strap <= 3'h2;
    bdis <= 1'b1;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("modes", 16'h0000, {12'h000, xb, ll, lt, rl});
    chk("irq", 16'h0001, {15'h0000, irq});
    rd(5'h02, 5'h00, 16'h3100);
    rd(5'h05, 5'h00, 16'hffff);
    rd(5'h00, 5'h16, 16'hffff);
    $display("end of strap tests");
    final_report();
  end
endmodule // pmilc_ctrl_tb
